//--- bench/txhf_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// dma requester model: takes requests, serves each one later
// ------------------------------------------------------------
module txhf_dma_model
    import txhf_pkg::*;
#(
    parameter int unsigned NUM_CH = 4
) (
    input  wire logic                core_clk_i,  // core clock
    input  wire logic                reset_n_i,   // async reset, active low
    input  wire logic [1:0]          stall_i,     // 0 prompt, 1 random, 2 held off
    input  wire logic                req_valid_i, // request waiting
    input  wire txhf_pkg::txhf_req_t req_i,       // request word
    output logic                     req_ready_o, // accept
    output logic [NUM_CH-1:0]        req_done_o   // request served, pulse
);
    logic [2:0] wait_r [NUM_CH];
    int         seed = 32'hbc5b;

    // a service delay of 1..4 cycles keeps several channels in flight at once
    always @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_ready_o <= 1'b0;
            req_done_o  <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                wait_r[i] <= 3'h0;
            end
        end else begin
            req_ready_o <= (stall_i == 2'h0) || (stall_i == 2'h1 && $random(seed) % 2 == 0);
            for (int i = 0; i < NUM_CH; i++) begin
                req_done_o[i] <= (wait_r[i] == 3'h1);
                if (wait_r[i] != 3'h0) wait_r[i] <= wait_r[i] - 3'h1;
            end
            if (req_valid_i && req_ready_o) wait_r[int'(req_i.ch) % NUM_CH] <= 3'h1 + 3'($unsigned($random(seed)) % 4);
        end
    end
endmodule // txhf_dma_model
`default_nettype wire

//--- bench/txhf_trig_tb.sv
`timescale 1ns/1ps
`default_nettype none
module txhf_trig_tb;
    import txhf_pkg::*;
    localparam int NCH = 4;
    logic                      core_clk_i, reset_n_i, stage_wr, prov_wr, prov_rd, len_en, req_ready, req_valid, busy;
    logic [7:0]                prov_ch;
    logic [3:0]                burst_max;
    logic [NCH-1:0][BLK_W-1:0] free_blk;
    logic [NCH-1:0]            eop, tx_act, req_done, start_tx, stuff_en, outst;
    logic [NCH-1:0][FILL_W-1:0] fill_min;
    logic [NCH-1:0][7:0]       fill_byte;
    txhf_prov_t                stage_data, stage_q, p, shadow [NCH];
    txhf_req_t                 req, q;
    logic [1:0]                stall;
    logic                      rq_on;
    int seed = 32'hbc5b;
    int err_total, samples_checked, ch, lvl, mi, c;
    int acc_cnt [NCH];

    txhf_trig #(.NUM_CH(NCH)) dut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .stage_wr_i(stage_wr),
        .stage_data_i(stage_data), .prov_wr_i(prov_wr), .prov_rd_i(prov_rd), .prov_ch_i(prov_ch),
        .dma_len_limit_enable_i(len_en), .burst_max_i(burst_max), .free_blocks_i(free_blk), .eop_stored_i(eop),
        .tx_active_i(tx_act), .req_done_i(req_done), .req_ready_i(req_ready), .req_valid_o(req_valid),
        .req_o(req), .stage_o(stage_q), .busy_o(busy), .start_tx_o(start_tx), .fill_min_o(fill_min),
        .fill_byte_o(fill_byte), .stuff_en_o(stuff_en));
    txhf_dma_model #(.NUM_CH(NCH)) dma (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .stall_i(stall),
        .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready), .req_done_o(req_done));

    // ------------------------------------------------------------
    // expectations, worked out from the level series
    // ------------------------------------------------------------
    function automatic int starve_f(int k);
        if (k >= 12) return 3 << (k - 6);
        return (k % 2) ? 3 << ((k - 1) / 2) : 2 << (k / 2);
    endfunction
    function automatic int start_f(logic m, int k);
        if (m) return (k <= 1) ? 1 : (k >= 12) ? 3 << (k - 7) : start_f(1'b0, k - 1);
        return (k == 0) ? 1 : (k >= 12) ? 1 << (k - 5) : starve_f(k - 1);
    endfunction
    function automatic logic exped_f(int i);
        return tx_act[i] && !eop[i] && free_blk[i] >= starve_f(shadow[i].level) && !shadow[i].low_priority_n;
    endfunction
    function automatic int blocks_f(int i);
        if (len_en && shadow[i].transfer_size_code == 4'h0) return (free_blk[i] < burst_max + 1) ? free_blk[i] : burst_max + 1;
        return shadow[i].transfer_size_code + 1;
    endfunction

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic prog(int k, txhf_prov_t v);
        stage_data = v;
        stage_wr = 1'b1;
        step(1);
        stage_wr = 1'b0;
        chk("stage_wr", v, stage_q);
        prov_ch = 8'(k);
        prov_wr = 1'b1; // staging is loaded before the write
        step(1);
        prov_wr = 1'b0;
        shadow[k] = v;
    endtask
    task automatic rdback(int k);
        stage_data = ~shadow[k];
        stage_wr = 1'b1;
        step(1);
        stage_wr = 1'b0;
        prov_ch = 8'(k);
        prov_rd = 1'b1;
        step(1);
        prov_rd = 1'b0;
        chk("busy", 1, busy);
        chk("stage_hold", txhf_prov_t'(~shadow[k]), stage_q);
        step(1);
        chk("busy_end", 0, busy);
        chk("stage_rd", shadow[k], stage_q);
    endtask
    task automatic check_out();
        for (int i = 0; i < NCH; i++) begin
            chk("start_tx", free_blk[i] <= start_f(shadow[i].start_mode_select, shadow[i].level) || eop[i], start_tx[i]);
            chk("fill_min", shadow[i].fill_idle ? (shadow[i].gap < 2 ? 0 : (1 << shadow[i].gap) - 2) : 1 << shadow[i].gap, fill_min[i]);
            chk("fill_byte", shadow[i].fill_idle ? 8'hff : 8'h7e, fill_byte[i]);
            chk("stuff_en", !shadow[i].fill_idle, stuff_en[i]);
        end
    endtask
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------
    // request monitor: every accepted word against its channel
    // ------------------------------------------------------------
    always @(posedge core_clk_i) begin
        if (req_valid && req_ready) begin
            mi = int'(req.ch) % NCH;
            chk("req_repeat", 0, outst[mi]);
            if (rq_on) begin
                chk("req_blocks", blocks_f(mi), req.blocks);
                chk("req_expedite", exped_f(mi), req.expedite);
                chk("req_allowed", 1, free_blk[mi] >= shadow[mi].transfer_size_code + 1 || exped_f(mi));
                acc_cnt[mi]++;
            end
        end
        outst = outst & ~req_done;
        if (req_valid && req_ready) outst[int'(req.ch) % NCH] = 1'b1;
    end

    // clock and hang guard
    initial begin
        core_clk_i = 1'b0;
        forever #2 core_clk_i = ~core_clk_i;
    end
    initial begin
        repeat (60000) @(posedge core_clk_i);
        err_total++;
        final_report();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        reset_n_i = 1'b0; stage_wr = 1'b0; prov_wr = 1'b0; prov_rd = 1'b0; prov_ch = 8'h00; stage_data = '0;
        len_en = 1'b0; burst_max = 4'h0; free_blk = '0; eop = '0; tx_act = '0; stall = 2'h0; rq_on = 1'b0;
        outst = '0; err_total = 0; samples_checked = 0;
        foreach (shadow[i]) shadow[i] = '0;
        repeat (3) @(posedge core_clk_i);
        #1 reset_n_i = 1'b1;
        // every level code in both start modes, every gap code with both fills
        for (c = 0; c < 32; c++) begin
            p = txhf_prov_t'(14'($random(seed)));
            p.level = c[3:0];
            p.start_mode_select = c[4];
            p.gap = c[2:0];
            p.fill_idle = c[3];
            ch = $unsigned($random(seed)) % NCH;
            prog(ch, p);
            rdback(ch);
            lvl = start_f(p.start_mode_select, p.level);
            for (int k = 0; k < 3; k++) begin
                free_blk[ch] = 12'(lvl + (k > 0));
                eop[ch] = (k == 2);
                step(2);
                check_out();
            end
        end
        // random request traffic; sizes kept at or under both levels
        for (int n = 0; n < 40; n++) begin
            len_en = 1'($random(seed));
            burst_max = 4'($random(seed));
            stall = 2'($unsigned($random(seed)) % 2);
            for (int i = 0; i < NCH; i++) begin
                p = txhf_prov_t'(14'($random(seed)));
                p.transfer_size_code = (n % 3 == 0) ? 4'h0 : 4'($unsigned($random(seed)) % 4);
                p.level = 4'h4 + 4'($unsigned($random(seed)) % 12);
                prog(i, p);
                c = $unsigned($random(seed)) % 4;
                free_blk[i] = (c == 3) ? 12'($random(seed)) : 12'(p.transfer_size_code + c - 1 + (c == 0));
                if (c == 0) free_blk[i] = 12'h000;
                tx_act[i] = 1'($random(seed));
                eop[i] = 1'($random(seed));
            end
            step(16);
            acc_cnt = '{default: 0};
            rq_on = 1'b1;
            step(40);
            rq_on = 1'b0;
            for (int i = 0; i < NCH; i++) begin
                chk("req_seen", free_blk[i] >= shadow[i].transfer_size_code + 1 || exped_f(i), acc_cnt[i] > 0);
            end
        end
        // far side stalls: the two-entry buffer fills and holds its word, then drains
        free_blk = '1;
        tx_act = '0;
        step(8);
        stall = 2'h2;
        step(8);
        q = req;
        step(6);
        chk("stall_valid", 1, req_valid);
        chk("stall_hold", q, req);
        free_blk = '0;
        stall = 2'h0;
        step(20);
        chk("drain_empty", 0, req_valid);
        final_report();
    end
endmodule // txhf_trig_tb
`default_nettype wire

//--- logic/txhf_trig.sv
`timescale 1ns/1ps
`default_nettype none
module txhf_trig
    import txhf_pkg::*;
#(
    parameter int unsigned NUM_CH = 4
) (
    input  wire logic                             core_clk_i,      // 250 MHz core clock
    input  wire logic                             reset_n_i,       // async reset, active low
    input  wire logic                             stage_wr_i,      // load staging register
    input  wire txhf_pkg::txhf_prov_t             stage_data_i,    // staging write data
    input  wire logic                             prov_wr_i,       // indirect channel write
    input  wire logic                             prov_rd_i,       // indirect channel read
    input  wire logic [7:0]                       prov_ch_i,       // channel for indirect access
    input  wire logic                             dma_len_limit_enable_i, // burst limiting
    input  wire logic [3:0]                       burst_max_i,     // burst maximum less one
    input  wire logic [NUM_CH-1:0][txhf_pkg::BLK_W-1:0] free_blocks_i, // free space per channel
    input  wire logic [NUM_CH-1:0]                eop_stored_i,    // end of packet in fifo
    input  wire logic [NUM_CH-1:0]                tx_active_i,     // packet being sent
    input  wire logic [NUM_CH-1:0]                req_done_i,      // request served, pulse
    input  wire logic                             req_ready_i,     // requester accepts
    output logic                                  req_valid_o,     // request waiting
    output txhf_pkg::txhf_req_t                   req_o,           // request word
    output txhf_pkg::txhf_prov_t                  stage_o,         // staging readback
    output logic                                  busy_o,          // indirect read running
    output logic [NUM_CH-1:0]                     start_tx_o,      // start transmission
    output logic [NUM_CH-1:0][txhf_pkg::FILL_W-1:0] fill_min_o,    // minimum fill count
    output logic [NUM_CH-1:0][7:0]                fill_byte_o,     // fill byte pattern
    output logic [NUM_CH-1:0]                     stuff_en_o       // bit stuffing on fill
);
    import txhf_pkg::*;

    localparam int unsigned CH_W = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

    // ------------------------------------------------------------
    // provisioning memory and staging register
    // ------------------------------------------------------------
    txhf_prov_t              mem_r   [NUM_CH];
    txhf_prov_t              mem_nxt [NUM_CH];
    txhf_prov_t              stage_r, stage_nxt;
    txhf_acc_t               acc_r, acc_nxt;
    logic [CH_W-1:0]         acc_ch_r, acc_ch_nxt;

    // a read lands one cycle later; a staging write in that cycle loses
    always_comb begin
        mem_nxt    = mem_r;
        stage_nxt  = stage_r;
        acc_nxt    = acc_r;
        acc_ch_nxt = acc_ch_r;
        if (stage_wr_i) begin
            stage_nxt = stage_data_i;
        end
        if (prov_wr_i) begin
            mem_nxt[prov_ch_i[CH_W-1:0]] = stage_r;
        end
        case (acc_r)
            ACC_IDLE: begin
                if (prov_rd_i) begin
                    acc_nxt    = ACC_READ;
                    acc_ch_nxt = prov_ch_i[CH_W-1:0];
                end
            end
            ACC_READ: begin
                stage_nxt = mem_r[acc_ch_r];
                acc_nxt   = ACC_IDLE;
            end
            default: acc_nxt = ACC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                mem_r[i] <= '0;
            end
            stage_r  <= '0;
            acc_r    <= ACC_IDLE;
            acc_ch_r <= '0;
        end else begin
            mem_r    <= mem_nxt;
            stage_r  <= stage_nxt;
            acc_r    <= acc_nxt;
            acc_ch_r <= acc_ch_nxt;
        end
    end

    // ------------------------------------------------------------
    // per-channel start and fill decisions
    // ------------------------------------------------------------
    logic [NUM_CH-1:0]             start_nxt;
    logic [NUM_CH-1:0][FILL_W-1:0] fill_min_nxt;
    logic [NUM_CH-1:0][7:0]        fill_byte_nxt;
    logic [NUM_CH-1:0]             stuff_nxt;
    logic [NUM_CH-1:0]             start_r, stuff_r;
    logic [NUM_CH-1:0][FILL_W-1:0] fill_min_r;
    logic [NUM_CH-1:0][7:0]        fill_byte_r;

    // each channel looks only at its own fields, free space and end-of-packet flag
    always_comb begin
        logic [BLK_W-1:0]  lvl;
        logic [FILL_W-1:0] flags;
        lvl   = '0;
        flags = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            lvl = mem_r[i].start_mode_select ? START_LVL1[mem_r[i].level]
                                             : START_LVL0[mem_r[i].level];
            start_nxt[i] = (free_blocks_i[i] <= lvl) || eop_stored_i[i];
            flags = FILL_W'(1) << mem_r[i].gap;
            if (mem_r[i].fill_idle) begin
                fill_min_nxt[i]  = (mem_r[i].gap < 3'h2) ? '0 : FILL_W'(flags - FILL_W'(2));
                fill_byte_nxt[i] = IDLE_BYTE;
                stuff_nxt[i]     = 1'b0;
            end else begin
                fill_min_nxt[i]  = flags;
                fill_byte_nxt[i] = FLAG_BYTE;
                stuff_nxt[i]     = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            start_r     <= '0;
            fill_min_r  <= '0;
            fill_byte_r <= '0;
            stuff_r     <= '0;
        end else begin
            start_r     <= start_nxt;
            fill_min_r  <= fill_min_nxt;
            fill_byte_r <= fill_byte_nxt;
            stuff_r     <= stuff_nxt;
        end
    end

    // ------------------------------------------------------------
    // request scan, one channel per cycle
    // ------------------------------------------------------------
    logic [CH_W-1:0]   scan_r, scan_nxt;
    logic [NUM_CH-1:0] pend_r, pend_nxt;
    logic              push, in_ready;
    txhf_req_t         push_req;

    // round robin keeps a busy channel from starving the others
    always_comb begin
        logic [BLK_W-1:0] fr;
        logic [BLK_W-1:0] xsz;
        logic [BLK_W-1:0] cap;
        logic             norm, expd;
        txhf_prov_t       p;
        p        = mem_r[scan_r];
        fr       = free_blocks_i[scan_r];
        xsz      = BLK_W'(p.transfer_size_code) + BLK_W'(1);
        cap      = BLK_W'(burst_max_i) + BLK_W'(1);
        norm     = fr >= xsz;
        expd     = tx_active_i[scan_r] && !eop_stored_i[scan_r]
                   && (fr >= STARVE_LVL[p.level]) && !p.low_priority_n;
        push_req = '0;
        push_req.ch       = 8'(scan_r);
        push_req.expedite = expd;
        push_req.blocks   = REQ_W'(xsz);
        if (dma_len_limit_enable_i && p.transfer_size_code == SIZE_VAR) begin
            push_req.blocks = REQ_W'((fr < cap) ? fr : cap);
        end
        push     = in_ready && !pend_r[scan_r] && (norm || expd) && (fr != '0);
        pend_nxt = (pend_r & ~req_done_i) | ((NUM_CH'(push)) << scan_r);
        scan_nxt = (scan_r == CH_W'(NUM_CH - 1)) ? '0 : CH_W'(scan_r + CH_W'(1));
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scan_r <= '0;
            pend_r <= '0;
        end else begin
            scan_r <= scan_nxt;
            pend_r <= pend_nxt;
        end
    end

    // ------------------------------------------------------------
    // two-entry buffer toward the dma requester
    // ------------------------------------------------------------
    txhf_req_t out_r, out_nxt, skid_r, skid_nxt;
    logic      out_v_r, out_v_nxt, skid_v_r, skid_v_nxt;
    logic      pop;

    // skid entry lets the output stay registered while ready drops
    always_comb begin
        pop        = out_v_r && req_ready_i;
        in_ready   = !skid_v_r;
        out_nxt    = out_r;
        skid_nxt   = skid_r;
        out_v_nxt  = out_v_r;
        skid_v_nxt = skid_v_r;
        if (skid_v_r) begin
            if (pop) begin
                out_nxt    = skid_r;
                skid_v_nxt = 1'b0;
            end
        end else if (push) begin
            if (!out_v_r || pop) begin
                out_nxt   = push_req;
                out_v_nxt = 1'b1;
            end else begin
                skid_nxt   = push_req;
                skid_v_nxt = 1'b1;
            end
        end else if (pop) begin
            out_v_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            out_r    <= '0;
            skid_r   <= '0;
            out_v_r  <= 1'b0;
            skid_v_r <= 1'b0;
        end else begin
            out_r    <= out_nxt;
            skid_r   <= skid_nxt;
            out_v_r  <= out_v_nxt;
            skid_v_r <= skid_v_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign req_valid_o = out_v_r;
    assign req_o       = out_r;
    assign stage_o     = stage_r;
    assign busy_o      = (acc_r == ACC_READ);
    assign start_tx_o  = start_r;
    assign fill_min_o  = fill_min_r;
    assign fill_byte_o = fill_byte_r;
    assign stuff_en_o  = stuff_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    req_hold_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        req_valid_o && !req_ready_i |=> req_valid_o && $stable(req_o))
        else $error("request changed while stalled");
    no_repeat_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        push |-> !pend_r[scan_r] ##1 pend_r[$past(scan_r)])
        else $error("request issued while one outstanding");
    low_prio_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        push && mem_r[scan_r].low_priority_n |-> !push_req.expedite)
        else $error("low priority channel expedited");
    burst_cap_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        push && dma_len_limit_enable_i |-> push_req.blocks <= REQ_W'(burst_max_i) + REQ_W'(1)
            || mem_r[scan_r].transfer_size_code != SIZE_VAR)
        else $error("variable burst above maximum");
    fixed_size_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        push && !dma_len_limit_enable_i |->
            push_req.blocks == REQ_W'(mem_r[scan_r].transfer_size_code) + REQ_W'(1))
        else $error("request size not transfer size plus one");
    start_eop_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        eop_stored_i[0] |=> start_tx_o[0])
        else $error("start missing with end of packet stored");
    idle_fill_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        mem_r[0].fill_idle |=> fill_byte_o[0] == IDLE_BYTE && !stuff_en_o[0])
        else $error("idle fill wrong");
    read_back_a: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        acc_r == ACC_IDLE && prov_rd_i ##1 !stage_wr_i |=> stage_o == $past(mem_r[acc_ch_r]))
        else $error("indirect read not shown in staging");
endmodule // txhf_trig
`default_nettype wire

//--- pkg/txhf_pkg.sv
`default_nettype none
package txhf_pkg;
    // ------------------------------------------------------------
    // widths and constants
    // ------------------------------------------------------------
    localparam int unsigned BLK_W       = 12;        // free space in 16-byte blocks
    localparam int unsigned BLOCK_BYTES = 16;        // bytes held by one block
    localparam int unsigned REQ_W       = 5;         // request length, 1..16 blocks
    localparam int unsigned FILL_W      = 8;         // fill count, up to 128
    localparam logic [7:0]  FLAG_BYTE   = 8'h7e;     // hdlc flag
    localparam logic [7:0]  IDLE_BYTE   = 8'hff;     // eight ones
    localparam logic [3:0]  SIZE_VAR    = 4'h0;      // code that allows a variable burst

    // ------------------------------------------------------------
    // level tables, indexed by trigger code
    // ------------------------------------------------------------
    localparam logic [BLK_W-1:0] START_LVL0 [16] = '{
        12'h001, 12'h002, 12'h003, 12'h004, 12'h006, 12'h008, 12'h00c, 12'h010,
        12'h018, 12'h020, 12'h030, 12'h040, 12'h080, 12'h100, 12'h200, 12'h400};
    localparam logic [BLK_W-1:0] START_LVL1 [16] = '{
        12'h001, 12'h001, 12'h002, 12'h003, 12'h004, 12'h006, 12'h008, 12'h00c,
        12'h010, 12'h018, 12'h020, 12'h030, 12'h060, 12'h0c0, 12'h180, 12'h300};
    localparam logic [BLK_W-1:0] STARVE_LVL [16] = '{
        12'h002, 12'h003, 12'h004, 12'h006, 12'h008, 12'h00c, 12'h010, 12'h018,
        12'h020, 12'h030, 12'h040, 12'h060, 12'h0c0, 12'h180, 12'h300, 12'h600};

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       start_mode_select;   // selects start level column
        logic       fill_idle;           // 1: all-ones fill, 0: flags
        logic       low_priority_n;      // 1: expedited requests inhibited
        logic [3:0] level;               // trigger level code
        logic [2:0] gap;                 // minimum fill code
        logic [3:0] transfer_size_code;  // blocks less one
    } txhf_prov_t;

    typedef struct packed {
        logic [7:0]       ch;            // channel number
        logic [REQ_W-1:0] blocks;        // blocks requested
        logic             expedite;      // expedited request
    } txhf_req_t;

    typedef enum logic [0:0] {ACC_IDLE, ACC_READ} txhf_acc_t;
endpackage
`default_nettype wire
